/* File: rtl/acs_result_hold.sv */
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_result_hold
   import acs_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic               load,
   input  wire acs_pkg::acs_result_t load_data,
   input  wire logic               latch_low,
   output logic [7:0]              result_high,
   output logic [1:0]              latched_low
);

   acs_result_t result_reg;
   acs_result_t data_meta_reg;
   acs_result_t data_sync_reg;
   logic [1:0]  low_hold_reg;

   // Converter word comes from the analog side: two flops before any use
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_meta_reg <= 10'h000;
         data_sync_reg <= 10'h000;
      end
      else
      begin
         data_meta_reg <= load_data;
         data_sync_reg <= data_meta_reg;
      end
   end

   // Newest result; each completion overwrites the last
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         result_reg <= 10'h000;
      else if (load)
         result_reg <= data_sync_reg;
   end

   // Low bits frozen at the high-byte read; left unreset on purpose
   always_ff @(posedge aclk)
   begin
      if (latch_low)
         low_hold_reg <= result_reg[1:0];
   end

   assign result_high = result_reg[9:2];
   assign latched_low = low_hold_reg;

endmodule : acs_result_hold

/* File: rtl/acs_top.sv */
// What this block does
// - After 160 idle cycles with no conversion, power the converter down.
// - From powered-down, spend 40 cycles powering up before converting.
// - A control-register write requesting conversion leaves the powered-down state.
// - Single-shot mode converts the selected channel once, then stops.
// - Four-bit channel field picks one of twelve analog inputs.
// - Continuous-select bit: 0 single-shot, 1 continuous.
// - Reference-control bit enables or disables the internal voltage reference.
// - Channel, mode, reference and start are taken in one write, start included.
// - Writing conversion-enable 1 starts; it reads 1 while single-shot runs.
// - Single-shot takes 5129 cycles, plus 40 power-up cycles when powered down.
// - Result bits 9..2 go to the high byte, bits 1..0 to low bits 7..6.
// - Single-shot completion clears conversion-enable to 0.
// - Every completed conversion, either mode, sends an interrupt request.
// - Continuous mode keeps converting; each result overwrites the previous one.
// - Continuous mode clears conversion-enable at first completion, keeps it 0.
// - After the first continuous result, a new result every 256 cycles.
// - High-byte read latches the low bits; low reads return the latched bits.
// - Low-bits register read-only; bits 7..6 hold result, 5..0 reserved.
// - Low result bits need no reset value; undefined until first latch.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_top
   import acs_pkg::*;
#(
   parameter int CONV_CYCLES = `ACS_CONV_CYCLES
)
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite write address
   input  wire logic [`ACS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [`ACS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Analog converter core
   input  wire acs_pkg::acs_result_t  converter_data,
   output acs_pkg::acs_chan_t         input_channel_select,
   output logic                       reference_enable,
   output logic                       converter_power_on,
   output logic                       converter_active,
   // Interrupt controller
   output logic                       conversion_irq
);

   localparam acs_count_t CONV_LAST = 13'(CONV_CYCLES - 1);
   localparam acs_count_t PWR_LAST  = `ACS_PWRUP_CYCLES - 13'h0001;
   localparam acs_count_t IDLE_LAST = `ACS_IDLE_CYCLES - 13'h0001;
   localparam acs_count_t CONTINUOUS_SELECT_LAST = `ACS_CONTINUOUS_SELECT_CYCLES - 13'h0001;

   // Register index match on a word-aligned byte address
   function automatic logic reg_match(input logic [`ACS_ADDR_W-1:0] addr,
                                      input logic [11:0] idx);
      reg_match = (addr == {idx, 2'b00});
   endfunction : reg_match

   // Counter terminal test, shared by every timed state
   function automatic logic count_done(input acs_count_t cnt, input acs_count_t last);
      count_done = (cnt == last);
   endfunction : count_done

   acs_state_t          state_reg;
   acs_state_t          state_next;
   acs_count_t          cnt_reg;
   acs_count_t          cnt_next;

   acs_chan_t           chan_reg;
   logic                continuous_select_reg;
   logic                ref_reg;
   logic                cen_reg;
   logic                irq_reg;

   logic                aw_held_reg;
   logic                w_held_reg;
   logic [`ACS_ADDR_W-1:0] aw_addr_reg;
   logic [31:0]         w_data_reg;
   logic [3:0]          w_strb_reg;
   logic                bvalid_reg;
   logic [1:0]          bresp_reg;
   logic                rvalid_reg;
   logic [31:0]         rdata_reg;
   logic [1:0]          rresp_reg;

   logic                do_write;
   logic                ctrl_write;
   logic                start_req;
   logic                ar_take;
   logic                high_read;
   logic                conv_done;
   logic [7:0]          result_high;
   logic [1:0]          latched_low;

   // Write channel: address and data taken independently, then applied together
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
   assign ctrl_write    = do_write && reg_match(aw_addr_reg, `ACS_IDX_CTRL) && w_strb_reg[0];
   // Start only when nothing is running; a busy write still updates fields
   assign start_req     = ctrl_write && w_data_reg[`ACS_CTRL_CEN_BIT] &&
                          (state_reg == ACS_ST_OFF || state_reg == ACS_ST_IDLE);

   // Held write address and data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (do_write)
            w_held_reg <= 1'b0;
      end
   end

   // Write response; read-only registers accept and ignore, unmapped gets an error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `ACS_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         if (reg_match(aw_addr_reg, `ACS_IDX_CTRL) || reg_match(aw_addr_reg, `ACS_IDX_HIGH) ||
             reg_match(aw_addr_reg, `ACS_IDX_LOW))
            bresp_reg <= `ACS_RESP_OKAY;
         else
            bresp_reg <= `ACS_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // Read channel: one read at a time, data from flops one cycle later
   assign s_axi_arready = !rvalid_reg;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign high_read     = ar_take && reg_match(s_axi_araddr, `ACS_IDX_HIGH);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `ACS_RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= `ACS_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
         if (reg_match(s_axi_araddr, `ACS_IDX_CTRL))
         begin
            rdata_reg[`ACS_CTRL_CHAN_MSB:`ACS_CTRL_CHAN_LSB] <= chan_reg;
            rdata_reg[`ACS_CTRL_CONTINUOUS_SELECT_BIT] <= continuous_select_reg;
            rdata_reg[`ACS_CTRL_REF_BIT]  <= ref_reg;
            rdata_reg[`ACS_CTRL_PWR_BIT]  <= (state_reg != ACS_ST_OFF);
            rdata_reg[`ACS_CTRL_CEN_BIT]  <= cen_reg;
         end
         else if (reg_match(s_axi_araddr, `ACS_IDX_HIGH))
            rdata_reg[7:0] <= result_high;
         else if (reg_match(s_axi_araddr, `ACS_IDX_LOW))
            rdata_reg[7:6] <= latched_low;   // Reserved 5..0 read zero
         else
            rresp_reg <= `ACS_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   // Control fields, all taken from one write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chan_reg <= `ACS_CTRL_CHAN_RST;
         continuous_select_reg <= 1'b0;
         ref_reg  <= 1'b0;
      end
      else if (ctrl_write)
      begin
         // Codes past the last input are clipped to keep the mux in range
         if (w_data_reg[`ACS_CTRL_CHAN_MSB:`ACS_CTRL_CHAN_LSB] < `ACS_NUM_CHANNELS)
            chan_reg <= w_data_reg[`ACS_CTRL_CHAN_MSB:`ACS_CTRL_CHAN_LSB];
         else
            chan_reg <= `ACS_NUM_CHANNELS - 4'h1;
         continuous_select_reg <= w_data_reg[`ACS_CTRL_CONTINUOUS_SELECT_BIT];
         ref_reg  <= w_data_reg[`ACS_CTRL_REF_BIT];
      end
   end

   // Completion of any conversion, first or repeated
   assign conv_done = (state_reg == ACS_ST_FIRST && count_done(cnt_reg, CONV_LAST)) ||
                      (state_reg == ACS_ST_CONTINUOUS_SELECT  && count_done(cnt_reg, CONTINUOUS_SELECT_LAST));

   // Sequencer next state
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 13'h0001;
      case (state_reg)
         ACS_ST_OFF:
         begin
            cnt_next = 13'h0000;
            if (start_req)
               state_next = ACS_ST_PWRUP;
         end
         ACS_ST_IDLE:
         begin
            if (start_req)
            begin
               state_next = ACS_ST_FIRST;   // Already powered, no wake-up cost
               cnt_next   = 13'h0000;
            end
            else if (count_done(cnt_reg, IDLE_LAST))
            begin
               state_next = ACS_ST_OFF;
               cnt_next   = 13'h0000;
            end
         end
         ACS_ST_PWRUP:
         begin
            if (count_done(cnt_reg, PWR_LAST))
            begin
               state_next = ACS_ST_FIRST;
               cnt_next   = 13'h0000;
            end
         end
         ACS_ST_FIRST:
         begin
            if (count_done(cnt_reg, CONV_LAST))
            begin
               cnt_next = 13'h0000;
               // Mode sampled at completion so a late mode change still counts
               if (continuous_select_reg)
                  state_next = ACS_ST_CONTINUOUS_SELECT;
               else
                  state_next = ACS_ST_IDLE;
            end
         end
         ACS_ST_CONTINUOUS_SELECT:
         begin
            if (!continuous_select_reg)
            begin
               state_next = ACS_ST_IDLE;      // Stop at once, partial result dropped
               cnt_next   = 13'h0000;
            end
            else if (count_done(cnt_reg, CONTINUOUS_SELECT_LAST))
               cnt_next = 13'h0000;
         end
         default:
         begin
            state_next = ACS_ST_OFF;
            cnt_next   = 13'h0000;
         end
      endcase
   end

   // Sequencer state and cycle counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ACS_ST_OFF;
         cnt_reg   <= 13'h0000;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Conversion-enable: set by a start, cleared at the first completion
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cen_reg <= 1'b0;
      else if (start_req)
         cen_reg <= 1'b1;
      else if (state_reg == ACS_ST_FIRST && conv_done)
         cen_reg <= 1'b0;
   end

   // One-cycle interrupt request per result
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= conv_done;
   end

   // Synchroniser, result store and low-bit latch
   acs_result_hold u_result_hold (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .load        (conv_done),
      .load_data   (converter_data),
      .latch_low   (high_read),
      .result_high (result_high),
      .latched_low (latched_low)
   );

   // Analog core controls
   assign input_channel_select = chan_reg;
   assign reference_enable     = ref_reg;
   assign converter_power_on   = (state_reg != ACS_ST_OFF);   // High through power-up too
   assign converter_active     = (state_reg == ACS_ST_FIRST) || (state_reg == ACS_ST_CONTINUOUS_SELECT);
   assign conversion_irq       = irq_reg;

endmodule : acs_top

/* File: shared/acs_params.svh */
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register indices; byte address is four times the index
`define ACS_IDX_CTRL        12'hf70
`define ACS_IDX_HIGH        12'hf72
`define ACS_IDX_LOW         12'hf73
`define ACS_ADDR_W          14

// Control register field positions
`define ACS_CTRL_CHAN_LSB   0
`define ACS_CTRL_CHAN_MSB   3
`define ACS_CTRL_CONTINUOUS_SELECT_BIT   4
`define ACS_CTRL_REF_BIT    5
`define ACS_CTRL_PWR_BIT    6
`define ACS_CTRL_CEN_BIT    7

// Channel reset value and number of channels
`define ACS_CTRL_CHAN_RST   4'h0
`define ACS_NUM_CHANNELS    4'hc

// Timing counts in system clock cycles
`define ACS_IDLE_CYCLES     13'h00a0
`define ACS_PWRUP_CYCLES    13'h0028
`define ACS_CONV_CYCLES     5129
`define ACS_CONTINUOUS_SELECT_CYCLES     13'h0100

// Bus response codes
`define ACS_RESP_OKAY       2'h0
`define ACS_RESP_SLVERR     2'h2

`endif

/* File: shared/acs_pkg.sv */
package acs_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      ACS_ST_OFF   = 3'b000,
      ACS_ST_IDLE  = 3'b001,
      ACS_ST_PWRUP = 3'b010,
      ACS_ST_FIRST = 3'b011,
      ACS_ST_CONTINUOUS_SELECT  = 3'b100
   } acs_state_t;

   typedef logic [9:0]  acs_result_t;
   typedef logic [3:0]  acs_chan_t;
   typedef logic [12:0] acs_count_t;

endpackage : acs_pkg

/* File: testbench/acs_conv_model.sv */
`timescale 1ns/1ps

module acs_conv_model
   import acs_pkg::*;
(
   input  wire logic               aclk,
   input  wire acs_pkg::acs_chan_t input_channel_select,
   input  wire logic               reference_enable,
   input  wire logic               converter_power_on,
   output acs_pkg::acs_result_t    converter_data
);
   initial converter_data = 10'h155;
   // Sample encodes channel and reference; unpowered it toggles, never stale
   always @(posedge aclk)
      if (converter_power_on)
         converter_data <= {input_channel_select, reference_enable,
                            input_channel_select ^ 4'h5, 1'b1};
      else
         converter_data <= ~converter_data;
endmodule : acs_conv_model

/* File: testbench/acs_top_assertions.sv */
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_checker
   import acs_pkg::*;
#(
   parameter int CONV_CYCLES = `ACS_CONV_CYCLES
)
(
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic [1:0]         s_axi_rresp,
   input wire acs_pkg::acs_chan_t input_channel_select,
   input wire logic               converter_power_on,
   input wire logic               converter_active,
   input wire logic               conversion_irq
);
   logic [15:0] act_cnt;
   logic [15:0] gap_cnt;
   logic [15:0] idle_cnt;
   logic        continuous_select_seen;

   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Cycle counters; reset folded in so no count starts unknown
   always_ff @(posedge aclk)
      act_cnt <= (!aresetn || !converter_active) ? 16'h0 : act_cnt + 16'h1;
   always_ff @(posedge aclk)
      gap_cnt <= (!aresetn || conversion_irq) ? 16'h1 : gap_cnt + 16'h1;
   always_ff @(posedge aclk)
      idle_cnt <= (!aresetn || !converter_power_on || converter_active) ? 16'h0
                  : idle_cnt + 16'h1;
   // Set once a result leaves the core running, so later gaps are stream gaps
   always_ff @(posedge aclk)
      continuous_select_seen <= aresetn && converter_active && (continuous_select_seen || conversion_irq);

   a_irq_pulse: assert property (conversion_irq |=> !conversion_irq)
      else $error("completion pulse longer than one cycle");
   a_pwrup_len: assert property ($rose(converter_power_on) |->
      (!converter_active)[*8] ##[32:34] $rose(converter_active))
      else $error("power-up phase not 40 cycles");
   a_first_conv: assert property (conversion_irq && !continuous_select_seen |->
      act_cnt >= CONV_CYCLES - 1 && act_cnt <= CONV_CYCLES + 1)
      else $error("first conversion length wrong");
   a_stream_gap: assert property (conversion_irq && continuous_select_seen |-> gap_cnt == 16'h0100)
      else $error("stream result spacing not 256");
   a_idle_off: assert property ($fell(converter_power_on) |->
      idle_cnt >= 16'h009f && idle_cnt <= 16'h00a1)
      else $error("power-down not after 160 idle cycles");
   a_idle_bound: assert property (idle_cnt <= 16'h00a2)
      else $error("idle converter left powered");
   a_active_pwr: assert property (converter_active |-> converter_power_on)
      else $error("converting while powered down");
   a_chan_range: assert property (input_channel_select <= 4'hb)
      else $error("channel select beyond last input");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");

   c_stream: cover property (conversion_irq && continuous_select_seen);
   c_pwr_down: cover property ($fell(converter_power_on));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `ACS_RESP_SLVERR);
endmodule : acs_checker

/* File: testbench/test_adc_conversion_sequencer.sv */
`timescale 1ns/1ps
`include "acs_params.svh"

module test_adc_conversion_sequencer;
   localparam int          CONV   = 300;
   localparam logic [13:0] A_CTRL = {`ACS_IDX_CTRL, 2'b00};
   localparam logic [13:0] A_HIGH = {`ACS_IDX_HIGH, 2'b00};
   localparam logic [13:0] A_LOW  = {`ACS_IDX_LOW, 2'b00};
   localparam logic [1:0]  OK     = `ACS_RESP_OKAY;
   localparam logic [1:0]  ERR    = `ACS_RESP_SLVERR;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [13:0] awaddr = 14'h0;
   logic [13:0] araddr = 14'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        bready = 1'b1;
   logic        rready = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid, pwr_on, active, irq, ref_en;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, t0;
   logic [3:0]  chan_sel;
   logic [9:0]  conv_data, d;
   int          cyc = 0, n_irq = 0, n_errors = 0, comparisons = 0;

   acs_top #(.CONV_CYCLES(CONV)) acs_top_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .converter_data(conv_data),
      .input_channel_select(chan_sel), .reference_enable(ref_en),
      .converter_power_on(pwr_on), .converter_active(active), .conversion_irq(irq));

   acs_conv_model acs_conv_model_i (
      .aclk(aclk), .input_channel_select(chan_sel), .reference_enable(ref_en),
      .converter_power_on(pwr_on), .converter_data(conv_data));

   always #20 aclk = ~aclk;

   // Cycle count for timing checks, result count, and the hang guard
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      n_irq <= n_irq + int'(irq);
      if (cyc == 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
                        input int tol = 0);
      comparisons++;
      if (!(got === exp || (tol > 0 && got + tol >= exp && got <= exp + tol)))
      begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   // Bus write; address and data offered together, each dropped when taken
   task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [1:0] er);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // Edge first: the last answer still shows in this time step
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (!(bvalid && bready));
      check("bresp", er, bresp);
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [31:0] exp, input logic [31:0] m,
                     input logic [1:0] er, input string what);
      araddr <= a;
      arvalid <= 1'b1;
      // Edge first, so a back-to-back read never takes the previous answer
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (!(rvalid && rready));
      check(what, exp & m, rdata & m);
      check("rresp", er, rresp);
   endtask : rd

   task automatic wait_irq();
      int n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!irq && n < 2000);
      check("completion pulse", 1, irq);
   endtask : wait_irq

   function automatic logic [31:0] ctrl_w(input logic conversion_enable, input logic rf, input logic continuous_select,
                                          input logic [3:0] ch);
      return {24'h0, conversion_enable, 1'b0, rf, continuous_select, ch};
   endfunction : ctrl_w

   function automatic logic [9:0] sample(input logic [3:0] ch, input logic rf);
      return {ch, rf, ch ^ 4'h5, 1'b1};
   endfunction : sample

   task automatic tally_and_finish();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // Single shots over every channel, the first from power-down, then a stream
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("power after reset", 0, pwr_on);
      rd(A_CTRL, 0, 32'hff, OK, "ctrl reset");
      for (int ch = 0; ch < 12; ch++)
      begin
         d = sample(ch[3:0], ch[0]);
         wr(A_CTRL, ctrl_w(1, ch[0], 0, ch[3:0]), OK);
         t0 = cyc;
         check("channel out", ch, chan_sel);
         check("reference out", ch[0], ref_en);
         rd(A_CTRL, ctrl_w(1, ch[0], 0, ch[3:0]), 32'hbf, OK, "ctrl busy");
         wait_irq();
         check("convert time", ch == 0 ? CONV + 40 : CONV, cyc - t0, 3);
         rd(A_CTRL, ctrl_w(0, ch[0], 0, ch[3:0]), 32'hbf, OK, "ctrl done");
         rd(A_HIGH, d[9:2], 32'hffffffff, OK, "high byte");
         rd(A_LOW, {d[1:0], 6'h0}, 32'hffffffff, OK, "low bits");
      end
      d = sample(4'h5, 1'b0);
      wr(A_CTRL, ctrl_w(1, 0, 1, 4'h5), OK);
      t0 = cyc;
      wait_irq();
      check("first stream result", CONV, cyc - t0, 3);
      rd(A_CTRL, ctrl_w(0, 0, 1, 4'h5), 32'hbf, OK, "ctrl streaming");
      wait_irq();
      t0 = cyc;
      wait_irq();
      check("stream period", 256, cyc - t0);
      rd(A_HIGH, d[9:2], 32'hff, OK, "stream high");
      wr(A_CTRL, ctrl_w(0, 0, 1, 4'h6), OK);
      wait_irq();
      wait_irq();
      rd(A_LOW, {d[1:0], 6'h0}, 32'hff, OK, "held low bits");
      d = sample(4'h6, 1'b0);
      rd(A_HIGH, d[9:2], 32'hff, OK, "new stream high");
      rd(A_LOW, {d[1:0], 6'h0}, 32'hff, OK, "new low bits");
      rd(A_CTRL, ctrl_w(0, 0, 1, 4'h6), 32'hbf, OK, "ctrl still clear");
      wr(A_CTRL, ctrl_w(0, 0, 0, 4'h6), OK);
      t0 = cyc;
      while (pwr_on && cyc - t0 < 1000)
         @(posedge aclk);
      check("idle to power down", 160, cyc - t0, 3);
      check("result count", 17, n_irq);
      wr(A_HIGH, 32'h0, OK);
      rd(A_HIGH, d[9:2], 32'hffffffff, OK, "high after write");
      wr(A_LOW, 32'h0, OK);
      rd(A_LOW, {d[1:0], 6'h0}, 32'hffffffff, OK, "low after write");
      wr(14'h0, 32'h0, ERR);
      rd(14'h0, 32'h0, 32'hffffffff, ERR, "unmapped read");
      wr(A_CTRL, ctrl_w(0, 0, 0, 4'hf), OK);
      rd(A_CTRL, ctrl_w(0, 0, 0, 4'hb), 32'hff, OK, "channel clipped");
      check("clipped channel out", 32'hb, chan_sel);
      tally_and_finish();
   end
endmodule : test_adc_conversion_sequencer

bind acs_top acs_checker #(.CONV_CYCLES(CONV_CYCLES)) acs_checker_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
   .input_channel_select(input_channel_select), .converter_power_on(converter_power_on),
   .converter_active(converter_active), .conversion_irq(conversion_irq));
